// ==== core/sldc_pkg.sv ====
/*
 * Shared constants for the serial lane deframer control block: register
 * offsets, field positions, reset values, control characters and states.
 * Assumes a byte-wide register port with 11-bit addresses.
 */
package sldc_pkg;

    // Register offsets
    localparam logic [10:0] SLDC_STATUS_ADDR = 11'h473;    // Lane alignment status, read only
    localparam logic [10:0] SLDC_PRIMARY_ADDR = 11'h475;   // Deframer control, primary
    localparam logic [10:0] SLDC_SECONDARY_ADDR = 11'h476; // Deframer control, secondary

    // Primary control fields
    localparam int unsigned SLDC_RX_OFF_BIT = 7;      // Receiver disable
    localparam int unsigned SLDC_SUBST_OFF_BIT = 6;   // Frame-end substitution off
    localparam int unsigned SLDC_SOFT_RST_BIT = 3;    // Deframer soft reset
    localparam int unsigned SLDC_FORCE_SYNC_BIT = 2;  // Forced sync request
    localparam int unsigned SLDC_ERR_REPL_BIT = 0;    // Errored frame replace on

    // Secondary control fields
    localparam int unsigned SLDC_DISP_QUAL_BIT = 4;   // Disparity error qualify
    localparam int unsigned SLDC_ALT_DESCR_BIT = 3;   // Alternative descrambler on
    localparam int unsigned SLDC_POST_SEL_BIT = 2;    // Post-alignment behaviour select
    localparam int unsigned SLDC_SKIP_ILAS_BIT = 1;   // Skip alignment sequence

    // Reset values and writable masks (reserved bits read zero)
    localparam logic [7:0] SLDC_PRIMARY_RESET = 8'h01;
    localparam logic [7:0] SLDC_SECONDARY_RESET = 8'h14;
    localparam logic [7:0] SLDC_PRIMARY_MASK = 8'hcd;
    localparam logic [7:0] SLDC_SECONDARY_MASK = 8'h1e;

    // Control characters (8b10b K codes)
    localparam logic [7:0] SLDC_CHAR_K = 8'hbc;  // Code group sync character
    localparam logic [7:0] SLDC_CHAR_R = 8'h1c;  // Multiframe start
    localparam logic [7:0] SLDC_CHAR_A = 8'h7c;  // Multiframe end
    localparam logic [7:0] SLDC_CHAR_F = 8'hfc;  // Frame end

    // Counts
    localparam logic [2:0] SLDC_CGS_K_COUNT = 3'h4;   // Consecutive /K/ for code group sync
    localparam logic [2:0] SLDC_ILAS_MF_COUNT = 3'h4; // Multiframes in the alignment sequence

    // Lane state machine, one-hot
    typedef enum logic [3:0] {
        SLDC_SEARCH = 4'b0001,
        SLDC_CGS = 4'b0010,
        SLDC_ILAS = 4'b0100,
        SLDC_DATA = 4'b1000
    } sldc_state_t;

endpackage

// ==== core/sldc_fifo.sv ====
/*
 * Small synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module sldc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } sldc_fifo_state_t;

    sldc_fifo_state_t s_reg; // Pointer state
    sldc_fifo_state_t s_next;
    logic [WIDTH-1:0] mem [DEPTH]; // Storage words
    logic do_wr;
    logic do_rd;

    // Wrap-aware pointer increment
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == LAST_SLOT) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_out = (s_reg.count != FULL_COUNT);
    assign out_valid_out = (s_reg.count != '0);
    assign out_data_out = mem[s_reg.rd_ptr];
    assign do_wr = in_valid_in & in_ready_out & ~flush_in;
    assign do_rd = out_valid_out & out_ready_in;

    // Pointer and count update; flush empties at once
    always_comb begin
        s_next = s_reg;
        if (do_wr) begin
            s_next.wr_ptr = bump(s_reg.wr_ptr);
        end
        if (do_rd) begin
            s_next.rd_ptr = bump(s_reg.rd_ptr);
        end
        if (do_wr && !do_rd) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (do_rd && !do_wr) begin
            s_next.count = s_reg.count - 1'b1;
        end
        if (flush_in) begin
            s_next = '0;
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage needs no reset; count guards reads
    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem[s_reg.wr_ptr] <= in_data_in;
        end
    end
endmodule

// ==== core/sldc_top.sv ====
/*
 * Serial lane deframer control: control and status registers, lane sync
 * state machine, frame-end and errored-frame substitution, output FIFO.
 * Assumes an internal byte-wide register port from the configuration
 * interface and one lane of decoded 8b10b characters, all on clk_in.
 */
`timescale 1ns/1ns
module sldc_top
    import sldc_pkg::*;
#(
    parameter logic [3:0] DISP_ERR_LIMIT = 4'h4, // Disparity errors that force resync
    parameter int unsigned FIFO_DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [10:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [4:0] lane_align_in,
    input wire logic char_valid_in,
    output logic char_ready_out,
    input wire logic [7:0] char_data_in,
    input wire logic char_is_k_in,
    input wire logic char_disp_err_in,
    input wire logic frame_end_in,
    input wire logic multiframe_end_in,
    input wire logic frame_error_in,
    output logic data_valid_out,
    input wire logic data_ready_in,
    output logic [7:0] data_out,
    output logic sync_request_out,
    output logic alt_descrambler_on_out
);
    typedef struct packed {
        logic [7:0] primary;      // Primary control register
        logic [7:0] secondary;    // Secondary control register
        logic [4:0] status;       // Per-lane alignment status
        logic [7:0] rdata;        // Read data
        sldc_state_t fsm;         // Lane sync state
        logic [2:0] kcnt;         // Consecutive /K/ count
        logic [2:0] mfcnt;        // Alignment multiframe count
        logic [3:0] errcnt;       // Disparity error count
        logic prev_k;             // Last character was /K/
        logic [7:0] last_octet;   // Final octet of the previous frame
        logic sync_req;           // Sync request toward transmitter
        logic alt_descr;          // Descrambler select toward datapath
    } sldc_state_reg_t;

    sldc_state_reg_t s_reg;
    sldc_state_reg_t s_next;
    logic fifo_ready; // FIFO can take a word
    logic push;       // Character enters the FIFO
    logic [7:0] push_data;
    logic active;     // Receiver running
    logic take;       // Character consumed this cycle
    logic is_k;
    logic k_fault;

    // Register readback decode
    function automatic logic [7:0] read_reg(input sldc_state_reg_t st, input logic [10:0] a);
        case (a)
            SLDC_STATUS_ADDR: read_reg = {3'h0, st.status};
            SLDC_PRIMARY_ADDR: read_reg = st.primary;
            SLDC_SECONDARY_ADDR: read_reg = st.secondary;
            default: read_reg = 8'h00; // Unmapped reads zero
        endcase
    endfunction

    assign active = ~s_reg.primary[SLDC_SOFT_RST_BIT] & ~s_reg.primary[SLDC_RX_OFF_BIT];
    // Disabled receiver still drains the source so the transmitter never stalls
    assign char_ready_out = fifo_ready | ~active;
    assign take = char_valid_in & active & fifo_ready;
    assign is_k = char_is_k_in & (char_data_in == SLDC_CHAR_K);
    assign k_fault = s_reg.prev_k & ~(char_is_k_in & (char_data_in == SLDC_CHAR_K
        || char_data_in == SLDC_CHAR_R));

    // Substitution of errored octets and frame-end control characters
    always_comb begin
        push_data = char_data_in;
        if (frame_error_in && s_reg.primary[SLDC_ERR_REPL_BIT]) begin
            push_data = s_reg.last_octet;
        end else if (!s_reg.primary[SLDC_SUBST_OFF_BIT] && char_is_k_in
            && ((frame_end_in && char_data_in == SLDC_CHAR_F)
            || (multiframe_end_in && char_data_in == SLDC_CHAR_A))) begin
            push_data = s_reg.last_octet;
        end
    end

    // Next state: lane sync, registers, outputs
    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        if (take) begin
            s_next.prev_k = is_k;
            case (s_reg.fsm)
                SLDC_SEARCH: begin
                    s_next.kcnt = is_k ? s_reg.kcnt + 1'b1 : 3'h0;
                    if (is_k && s_reg.kcnt == SLDC_CGS_K_COUNT - 3'h1) begin
                        s_next.fsm = SLDC_CGS;
                        s_next.kcnt = 3'h0;
                        s_next.errcnt = 4'h0;
                    end
                end
                SLDC_CGS: begin
                    if (is_k) begin
                        s_next.fsm = SLDC_CGS; // Still in sync pattern
                    end else if (s_reg.secondary[SLDC_SKIP_ILAS_BIT]) begin
                        s_next.fsm = SLDC_DATA;
                        push = 1'b1;
                    end else if (char_is_k_in && char_data_in == SLDC_CHAR_R) begin
                        s_next.fsm = SLDC_ILAS;
                        s_next.mfcnt = 3'h0;
                    end
                end
                SLDC_ILAS: begin
                    if (multiframe_end_in) begin
                        s_next.mfcnt = s_reg.mfcnt + 1'b1;
                        if (s_reg.mfcnt == SLDC_ILAS_MF_COUNT - 3'h1) begin
                            s_next.fsm = SLDC_DATA;
                        end
                    end
                end
                SLDC_DATA: begin
                    push = 1'b1;
                end
                default: begin
                    s_next.fsm = SLDC_SEARCH;
                end
            endcase
            // Loss of sync after code group sync
            if (s_reg.fsm != SLDC_SEARCH) begin
                if (s_reg.secondary[SLDC_POST_SEL_BIT]) begin
                    // Without the alignment sequence user data follows the last /K/, so that is no fault
                    if (k_fault && !(s_reg.fsm == SLDC_CGS && s_reg.secondary[SLDC_SKIP_ILAS_BIT])) begin
                        s_next.fsm = SLDC_SEARCH;
                        push = 1'b0;
                    end
                end else if (char_disp_err_in) begin
                    s_next.errcnt = s_reg.errcnt + 1'b1;
                    if (s_reg.errcnt == DISP_ERR_LIMIT - 4'h1) begin
                        s_next.fsm = SLDC_SEARCH;
                        push = 1'b0;
                    end
                end
            end
            if (push && (frame_end_in || multiframe_end_in)) begin
                s_next.last_octet = push_data;
            end
        end
        s_next.status = lane_align_in;
        // Soft reset holds the deframer at its power-on state
        if (s_reg.primary[SLDC_SOFT_RST_BIT]) begin
            s_next.status = 5'h00;
            s_next.fsm = SLDC_SEARCH;
            s_next.kcnt = 3'h0;
            s_next.mfcnt = 3'h0;
            s_next.errcnt = 4'h0;
            s_next.prev_k = 1'b0;
            s_next.last_octet = 8'h00;
            push = 1'b0;
        end
        if (reg_wr_in && reg_addr_in == SLDC_PRIMARY_ADDR) begin
            s_next.primary = reg_wdata_in & SLDC_PRIMARY_MASK;
        end
        if (reg_wr_in && reg_addr_in == SLDC_SECONDARY_ADDR) begin
            s_next.secondary = reg_wdata_in & SLDC_SECONDARY_MASK;
        end
        s_next.sync_req = s_reg.primary[SLDC_FORCE_SYNC_BIT] | (s_next.fsm == SLDC_SEARCH);
        s_next.alt_descr = s_reg.secondary[SLDC_ALT_DESCR_BIT];
        s_next.rdata = read_reg(s_reg, reg_addr_in);
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_reg <= '0;
            s_reg.primary <= SLDC_PRIMARY_RESET;
            s_reg.secondary <= SLDC_SECONDARY_RESET;
            s_reg.fsm <= SLDC_SEARCH;
            s_reg.sync_req <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_out = s_reg.rdata;
    assign sync_request_out = s_reg.sync_req;
    assign alt_descrambler_on_out = s_reg.alt_descr;

    // Output buffer; flushed by soft reset
    sldc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) sldc_fifo_i (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .flush_in(s_reg.primary[SLDC_SOFT_RST_BIT]),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in(push_data),
        .out_valid_out(data_valid_out),
        .out_ready_in(data_ready_in),
        .out_data_out(data_out)
    );

    status_soft_rst_a: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reg.primary[SLDC_SOFT_RST_BIT] |=> s_reg.status == 5'h00)
        else $error("Status not cleared in soft reset");
    rx_disable_a: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reg.primary[SLDC_RX_OFF_BIT] |-> !push)
        else $error("Push while receiver disabled");
    subst_off_a: assert property (@(posedge clk_in) disable iff (srst_in)
        push && s_reg.primary[SLDC_SUBST_OFF_BIT] && !frame_error_in |-> push_data == char_data_in)
        else $error("Substitution while disabled");
    soft_rst_fsm_a: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reg.primary[SLDC_SOFT_RST_BIT] |=> s_reg.fsm == SLDC_SEARCH && sync_request_out)
        else $error("Soft reset left deframer running");
    forced_sync_a: assert property (@(posedge clk_in) disable iff (srst_in)
        s_reg.primary[SLDC_FORCE_SYNC_BIT] [*2] |-> sync_request_out)
        else $error("Forced sync request not asserted");
    err_replace_a: assert property (@(posedge clk_in) disable iff (srst_in)
        push && frame_error_in && s_reg.primary[SLDC_ERR_REPL_BIT] |-> push_data == s_reg.last_octet)
        else $error("Errored octet not replaced");
    alt_descr_a: assert property (@(posedge clk_in) disable iff (srst_in)
        ##1 alt_descrambler_on_out == $past(s_reg.secondary[SLDC_ALT_DESCR_BIT]))
        else $error("Descrambler select mismatch");
    disp_mode_a: assert property (@(posedge clk_in) disable iff (srst_in)
        take && s_reg.fsm == SLDC_DATA && !s_reg.secondary[SLDC_POST_SEL_BIT] && !char_disp_err_in
        && !s_reg.primary[SLDC_SOFT_RST_BIT] |=> s_reg.fsm == SLDC_DATA)
        else $error("Resync without disparity error");
    k_fault_a: assert property (@(posedge clk_in) disable iff (srst_in)
        take && k_fault && s_reg.fsm != SLDC_SEARCH && s_reg.secondary[SLDC_POST_SEL_BIT]
        && !(s_reg.fsm == SLDC_CGS && s_reg.secondary[SLDC_SKIP_ILAS_BIT])
        |=> s_reg.fsm == SLDC_SEARCH ##1 sync_request_out)
        else $error("K fault did not request sync");
    skip_ilas_a: assert property (@(posedge clk_in) disable iff (srst_in)
        take && s_reg.fsm == SLDC_CGS && !char_is_k_in && s_reg.secondary[SLDC_SKIP_ILAS_BIT]
        && !s_reg.primary[SLDC_SOFT_RST_BIT] && !char_disp_err_in
        |-> push)
        else $error("User data after sync not taken");
endmodule

// ==== testbench/sldc_tx_model.sv ====
/*
 * Behavioural transmitter framer feeding one lane of decoded characters.
 * Assumes the bench mirrors the deframer settings onto its inputs.
 */
`timescale 1ns/1ns
module sldc_tx_model
    import sldc_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic sync_request_in,
    input wire logic skip_ilas_in,
    input wire logic subst_off_in,
    input wire logic replace_on_in,
    input wire logic err_in,
    input wire logic disp_in,
    input wire logic bad_k_in,
    input wire logic char_ready_in,
    output logic char_valid_out,
    output logic [7:0] char_data_out,
    output logic char_is_k_out,
    output logic char_disp_err_out,
    output logic frame_end_out,
    output logic multiframe_end_out,
    output logic frame_error_out,
    output logic note_valid_out,
    output logic [7:0] note_data_out
);
    logic [3:0] pos_reg; // Octet within multiframe, four frames of four
    logic [2:0] mf_reg; // Alignment multiframes sent
    logic noted_reg; // Current octet is user data
    logic [7:0] exp_reg; // Octet the deframer should deliver
    logic [7:0] last_reg; // Final octet of the previous frame
    logic [7:0] v; // Scratch octet
    logic fin; // Scratch: frame-final position

    // One octet per handshake, held until the deframer takes it
    always @(posedge clk_in) begin
        note_valid_out <= 1'b0;
        if (srst_in) begin
            char_valid_out <= 1'b0;
            char_data_out <= ~char_data_out; // Idle line never repeats a stale octet
            pos_reg <= 4'h0;
            mf_reg <= 3'h0;
            noted_reg <= 1'b0;
            last_reg <= 8'h00;
        end else if (!char_valid_out || char_ready_in) begin
            // Expected octet handed to the bench once accepted
            if (char_valid_out && noted_reg) begin
                note_valid_out <= 1'b1;
                note_data_out <= exp_reg;
            end
            char_valid_out <= 1'b1;
            {char_is_k_out, char_disp_err_out, frame_end_out, multiframe_end_out, frame_error_out} <= 5'h00;
            noted_reg <= 1'b0;
            pos_reg <= pos_reg + 4'h1;
            if (sync_request_in) begin
                // Sync request answered with a stream of /K/
                char_data_out <= SLDC_CHAR_K;
                char_is_k_out <= 1'b1;
                pos_reg <= 4'h0;
                mf_reg <= 3'h0;
                last_reg <= 8'h00;
            end else if (!skip_ilas_in && mf_reg != 3'h4) begin
                // Alignment sequence: /R/ opens and /A/ closes each multiframe
                char_is_k_out <= (pos_reg == 4'h0) || (pos_reg == 4'hf);
                char_data_out <= (pos_reg == 4'h0) ? SLDC_CHAR_R : (pos_reg == 4'hf) ? SLDC_CHAR_A : {4'h0, pos_reg};
                multiframe_end_out <= pos_reg == 4'hf;
                if (pos_reg == 4'hf) begin
                    mf_reg <= mf_reg + 3'h1;
                end
            end else begin
                // User data; half the frame ends repeat the previous one
                v = 8'($urandom);
                fin = pos_reg[1:0] == 2'h3;
                if (fin && $urandom % 2 == 0) begin
                    v = last_reg;
                end
                frame_end_out <= fin;
                multiframe_end_out <= pos_reg == 4'hf;
                char_disp_err_out <= disp_in;
                noted_reg <= 1'b1;
                exp_reg <= v;
                char_data_out <= v;
                if (fin) begin
                    last_reg <= v;
                end
                if (bad_k_in && !fin) begin
                    // Stray /K/ inside data
                    char_data_out <= SLDC_CHAR_K;
                    char_is_k_out <= 1'b1;
                    noted_reg <= 1'b0;
                end else if (fin && v == last_reg) begin
                    // Repeated frame end sent as /F/ or /A/
                    char_data_out <= (pos_reg == 4'hf) ? SLDC_CHAR_A : SLDC_CHAR_F;
                    char_is_k_out <= 1'b1;
                    exp_reg <= !subst_off_in ? v : (pos_reg == 4'hf) ? SLDC_CHAR_A : SLDC_CHAR_F;
                end else if (err_in && !fin) begin
                    frame_error_out <= 1'b1;
                    exp_reg <= replace_on_in ? last_reg : v;
                end
            end
        end
    end
endmodule

// ==== testbench/serial_lane_deframer_control_tb.sv ====
/*
 * Self-checking bench: register tasks, transmitter model, output compare.
 * Assumes the design top and package compile first.
 */
`timescale 1ns/1ns
module serial_lane_deframer_control_tb;
    import sldc_pkg::*;
    logic clk_in, srst_in, reg_wr_in, data_ready_in, data_valid_out, sync_request_out, alt_descrambler_on_out;
    logic [10:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, data_out, note_data, char_data;
    logic [4:0] lane_align_in;
    logic char_valid, char_ready_out, char_is_k, char_disp, f_end, mf_end, f_err, note_valid;
    logic cfg_skip, cfg_subst_off, cfg_repl, err, disp, bad_k, loose, rd_chk, stall;
    logic [7:0] exp_q[$]; // Expected data octets, oldest first
    logic [7:0] rd_q[$]; // Expected register reads
    int n_fail, comparisons, i;

    sldc_top #(.DISP_ERR_LIMIT(4'h4), .FIFO_DEPTH(4)) sldc_top_i (.clk_in(clk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .lane_align_in(lane_align_in), .char_valid_in(char_valid), .char_ready_out(char_ready_out),
        .char_data_in(char_data), .char_is_k_in(char_is_k), .char_disp_err_in(char_disp), .frame_end_in(f_end),
        .multiframe_end_in(mf_end), .frame_error_in(f_err), .data_valid_out(data_valid_out),
        .data_ready_in(data_ready_in), .data_out(data_out), .sync_request_out(sync_request_out),
        .alt_descrambler_on_out(alt_descrambler_on_out));
    sldc_tx_model sldc_tx_model_i (.clk_in(clk_in), .srst_in(srst_in), .sync_request_in(sync_request_out),
        .skip_ilas_in(cfg_skip), .subst_off_in(cfg_subst_off), .replace_on_in(cfg_repl), .err_in(err),
        .disp_in(disp), .bad_k_in(bad_k), .char_ready_in(char_ready_out), .char_valid_out(char_valid),
        .char_data_out(char_data), .char_is_k_out(char_is_k), .char_disp_err_out(char_disp), .frame_end_out(f_end),
        .multiframe_end_out(mf_end), .frame_error_out(f_err), .note_valid_out(note_valid), .note_data_out(note_data));

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wr_in <= 1'b1;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data lands one cycle after the address; watcher compares it
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        rd_q.push_back(e);
        @(posedge clk_in);
        rd_chk <= 1'b1;
        @(posedge clk_in);
        rd_chk <= 1'b0;
    endtask

    // Bounded wait on the sync request level; running out ends the run
    task automatic wait_sync(input logic v, input int bound);
        for (i = 0; i < bound && sync_request_out !== v; i++) @(posedge clk_in);
        check("sync_request_out", {7'h0, v}, {7'h0, sync_request_out});
        if (sync_request_out !== v) give_verdict();
    endtask

    // Settings changed only under soft reset, then link brought up again
    task automatic relink(input logic [7:0] p, input logic [7:0] s, input logic skip);
        loose <= 1'b1;
        wr(SLDC_PRIMARY_ADDR, p | 8'h08);
        cfg_skip <= skip;
        cfg_subst_off <= p[6];
        cfg_repl <= p[0];
        wr(SLDC_SECONDARY_ADDR, s);
        wr(SLDC_PRIMARY_ADDR, p);
        wait_sync(1'b0, 400);
        loose <= 1'b0;
    endtask

    // Watcher: notes in, results out, oldest note compared; consumer stalls at random
    always @(posedge clk_in) begin
        if (loose) exp_q.delete();
        else if (note_valid) exp_q.push_back(note_data);
        if (rd_chk) check("reg_rdata_out", rd_q.pop_front(), reg_rdata_out);
        if (!loose && data_valid_out && data_ready_in) begin
            if (exp_q.size() == 0) check("data_out spare", 8'h00, 8'h01);
            else check("data_out", exp_q.pop_front(), data_out);
        end
        data_ready_in <= !stall && ($urandom % 4 != 0);
    end

    initial begin
        {reg_addr_in, reg_wr_in, reg_wdata_in, err, disp, bad_k, rd_chk, stall, cfg_skip, cfg_subst_off} = '0;
        {srst_in, loose, cfg_repl, data_ready_in} = 4'hf;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(32'hbf28f917));
        lane_align_in = 5'h00; // Live lane values only after the reset value is read
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        check("sync_request_out", 8'h01, {7'h0, sync_request_out});
        check("alt_descrambler_on_out", 8'h00, {7'h0, alt_descrambler_on_out});
        rd(SLDC_PRIMARY_ADDR, 8'h01);
        rd(SLDC_SECONDARY_ADDR, 8'h14);
        rd(SLDC_STATUS_ADDR, 8'h00);
        wr(SLDC_PRIMARY_ADDR, 8'hff);
        rd(SLDC_PRIMARY_ADDR, 8'hcd);
        wr(11'h470, 8'h55);
        rd(11'h470, 8'h00);
        wr(SLDC_STATUS_ADDR, 8'hff);
        rd(SLDC_STATUS_ADDR, 8'h00);
        wr(SLDC_SECONDARY_ADDR, 8'hff);
        rd(SLDC_SECONDARY_ADDR, 8'h1e);
        check("alt_descrambler_on_out", 8'h01, {7'h0, alt_descrambler_on_out});
        // Full alignment sequence, errored frames replaced
        lane_align_in <= 5'($urandom) | 5'h01;
        relink(8'h01, 8'h14, 1'b0);
        repeat (200) @(posedge clk_in);
        wr(SLDC_STATUS_ADDR, 8'h00);
        rd(SLDC_STATUS_ADDR, {3'h0, lane_align_in});
        err <= 1'b1;
        repeat (30) @(posedge clk_in);
        err <= 1'b0;
        // Consumer stalls: buffer fills and refuses, then drains
        stall <= 1'b1;
        repeat (30) @(posedge clk_in);
        check("char_ready_out", 8'h00, {7'h0, char_ready_out});
        stall <= 1'b0;
        repeat (60) @(posedge clk_in);
        // Forced sync request stands while the bit stays set
        loose <= 1'b1;
        wr(SLDC_PRIMARY_ADDR, 8'h05);
        @(posedge clk_in);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_in);
            check("sync_request_out", 8'h01, {7'h0, sync_request_out});
        end
        // Substitution off, replacement off, disparity-only resync
        relink(8'h40, 8'h10, 1'b0);
        err <= 1'b1;
        repeat (150) @(posedge clk_in);
        err <= 1'b0;
        loose <= 1'b1;
        disp <= 1'b1;
        wait_sync(1'b1, 100);
        disp <= 1'b0;
        // Single lane without alignment sequence; status not read here
        relink(8'h01, 8'h16, 1'b1);
        repeat (200) @(posedge clk_in);
        loose <= 1'b1;
        bad_k <= 1'b1;
        wait_sync(1'b1, 100);
        bad_k <= 1'b0;
        // Receiver disabled: characters swallowed, link never comes up
        wr(SLDC_PRIMARY_ADDR, 8'h89);
        wr(SLDC_PRIMARY_ADDR, 8'h81);
        repeat (50) @(posedge clk_in);
        check("sync_request_out", 8'h01, {7'h0, sync_request_out});
        check("data_valid_out", 8'h00, {7'h0, data_valid_out});
        check("char_ready_out", 8'h01, {7'h0, char_ready_out});
        give_verdict();
    end
endmodule
